// ===== gpct_pkg.sv
// Shared constants and types for the general-purpose counter/timer block.
package gpct_pkg;

  // ---------------------------------------------------------------
  // Clocking and division
  // ---------------------------------------------------------------
  // mclk rate and the board clock rate that the internal board tick imitates.
  localparam int MCLK_HZ = 50_000_000;
  localparam int BOARD_HZ = 10_000_000;
  localparam int BOARD_DIV = MCLK_HZ / BOARD_HZ;
  localparam logic [2:0] BOARD_LAST = 3'(BOARD_DIV - 1);
  // The counter input clock is the selected board clock divided by ten.
  localparam int PRESCALE_DIV = 10;
  localparam logic [3:0] PRE_LAST = 4'(PRESCALE_DIV - 1);
  localparam logic [3:0] PRE_HALF = 4'(PRESCALE_DIV / 2);
  // Timebase zero runs at the prescaler rate; each later timebase is the previous one divided by ten.
  localparam int TB_DIV = 10;
  localparam logic [3:0] TB_LAST = 4'(TB_DIV - 1);
  localparam logic [3:0] TB_HALF = 4'(TB_DIV / 2);
  localparam int NUM_TB = 5;

  // ---------------------------------------------------------------
  // Counters and source selection
  // ---------------------------------------------------------------
  localparam int NUM_CNT = 3;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic OUT_RST = 1'b0;
  // Source pool: source pins, then gate pins, then timebases.
  localparam int POOL_W = 2 * NUM_CNT + NUM_TB;
  localparam logic [3:0] SEL_SRC0 = 4'h0;
  localparam logic [3:0] SEL_GATE0 = 4'h3;
  localparam logic [3:0] SEL_TB0 = 4'h6;
  localparam logic [3:0] FDIV_CNT_RST = 4'h0;

  // Gating modes of one counter.
  typedef enum logic [1:0] {GATE_NONE, GATE_LEVEL, GATE_EDGE} gate_mode_t;

endpackage

// ===== gpct_channel.sv
// One 16-bit counter channel with gating and terminal-count output.
`timescale 1ns/1ps
module gpct_channel
  import gpct_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; state freezes while low.
  input wire logic arm, // Counter armed; low clears the count.
  input wire logic src_lvl, // Selected count-source level.
  input wire logic gate_lvl, // Gate pin level.
  input wire logic edge_fall, // Count falling edges when high.
  input wire gate_mode_t gate_mode, // Gating mode.
  input wire logic gate_high, // Level gate active high, or edge gate rising.
  input wire logic out_toggle, // Output toggles at terminal count when high.
  input wire logic [CNT_W-1:0] limit, // Terminal count value.
  output logic [CNT_W-1:0] count_q, // Accumulated count.
  output logic out_q // Counter output.
);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} chan_state_t;

  chan_state_t state_q, state_d;
  logic src_q;
  logic gate_q;
  logic [CNT_W-1:0] count_d;
  logic out_d;
  wire src_edge;
  wire gate_edge;
  wire gate_ok;
  wire count_en;
  wire at_tc;
  wire tc_hit;

  // ---------------------------------------------------------------
  // Edge and gate decode
  // ---------------------------------------------------------------
  // Active source edge follows the chosen polarity; gate is judged on its registered copy.
  assign src_edge = edge_fall ? (src_q & ~src_lvl) : (~src_q & src_lvl);
  assign gate_edge = gate_high ? (~gate_q & gate_lvl) : (gate_q & ~gate_lvl);
  assign gate_ok = (gate_mode != GATE_LEVEL) || (gate_q == gate_high);
  assign count_en = (state_q == ST_RUN) && src_edge && gate_ok;
  assign at_tc = (count_q == limit);
  assign tc_hit = count_en && at_tc;

  // Arming and edge-gate start sequence.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (arm)
          state_d = (gate_mode == GATE_EDGE) ? ST_WAIT : ST_RUN;
      end
      ST_WAIT:
      begin
        if (!arm)
          state_d = ST_IDLE;
        else if (gate_edge)
          state_d = ST_RUN;
      end
      default:
      begin
        if (!arm)
          state_d = ST_IDLE;
      end
    endcase
  end

  // Count wraps to zero after the terminal count.
  assign count_d = !arm ? COUNT_RST :
                   tc_hit ? COUNT_RST :
                   count_en ? count_q + 16'h0001 : count_q;

  // Pulse mode holds for one source period; toggle mode inverts.
  assign out_d = !arm ? OUT_RST :
                 out_toggle ? (out_q ^ tc_hit) :
                 src_edge ? tc_hit : out_q;

  // State registers.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      src_q <= 1'b0;
      gate_q <= 1'b0;
      count_q <= COUNT_RST;
      out_q <= OUT_RST;
    end
    else if (ce)
    begin
      state_q <= state_d;
      src_q <= src_lvl;
      gate_q <= gate_lvl;
      count_q <= count_d;
      out_q <= out_d;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence run_edge_s;
    ce && arm && state_q == ST_RUN && src_edge && !at_tc;
  endsequence

  count_step_a: assert property ((run_edge_s and gate_ok) |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not step on an active edge");
  gate_hold_a: assert property (ce && arm && gate_mode == GATE_LEVEL && gate_q != gate_high
      |=> count_q == $past(count_q))
    else $error("count moved while gated off");
  level_gate_a: assert property ((run_edge_s and (gate_mode == GATE_LEVEL && gate_q == gate_high))
      |=> count_q != $past(count_q))
    else $error("count held while gate level active");
  edge_start_a: assert property (ce && arm && state_q == ST_WAIT && gate_edge
      |=> state_q == ST_RUN ##1 (state_q == ST_RUN || !$past(arm)))
    else $error("edge gate did not start the counter");
  wait_hold_a: assert property (ce && arm && state_q == ST_WAIT |=> count_q == $past(count_q))
    else $error("count moved before the gate edge");
  toggle_out_a: assert property (ce && arm && out_toggle && tc_hit |=> out_q != $past(out_q))
    else $error("output did not toggle at terminal count");
  pulse_out_a: assert property (ce && arm && !out_toggle && tc_hit |=> out_q)
    else $error("output pulse missing at terminal count");
  tc_wrap_a: assert property (ce && arm && tc_hit |=> count_q == COUNT_RST)
    else $error("count did not wrap at terminal count");
  wrong_edge_a: assert property (ce && arm && edge_fall && !src_q && src_lvl
      |=> count_q == $past(count_q))
    else $error("falling-edge counter moved on a rising edge");

endmodule

// ===== gpct_top.sv
// Three-counter general-purpose timer with timebases and frequency division output.
`timescale 1ns/1ps
module gpct_top
  import gpct_pkg::*;
(
  input wire logic mclk, // System clock, 50 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; all state freezes while low.
  input wire logic board_clk_sel, // Board clock select: 0 internal 10 MHz, 1 alternate pin.
  input wire logic alt_board_clk, // Alternate board clock level.
  input wire logic [NUM_CNT-1:0] src_pin, // Count-source pins.
  input wire logic [NUM_CNT-1:0] gate_pin, // Gate pins, one per counter.
  input wire logic [NUM_CNT-1:0] cnt_arm, // Arm each counter.
  input wire logic [3:0] cnt_src_sel [NUM_CNT], // Source select per counter.
  input wire logic [NUM_CNT-1:0] cnt_edge_fall, // Count falling edges when high.
  input wire gate_mode_t cnt_gate_mode [NUM_CNT], // Gating mode per counter.
  input wire logic [NUM_CNT-1:0] cnt_gate_high, // Gate polarity per counter.
  input wire logic [NUM_CNT-1:0] cnt_out_toggle, // Toggle output mode per counter.
  input wire logic [CNT_W-1:0] cnt_limit [NUM_CNT], // Terminal count per counter.
  input wire logic fdiv_en, // Enable the frequency division output.
  input wire logic [3:0] fdiv_src_sel, // Source select of the division output.
  input wire logic [3:0] fdiv_ratio, // Division ratio, zero means sixteen.
  output logic [NUM_CNT-1:0] cnt_out, // Counter outputs.
  output logic [CNT_W-1:0] cnt_value [NUM_CNT], // Counter values.
  output logic freq_division_output // Frequency division output.
);

  logic [2:0] board_div_q;
  logic alt_q;
  logic [3:0] pre_q;
  logic [3:0] tb_cnt_q [NUM_TB];
  logic [NUM_TB-1:0] tb_lvl_q;
  logic [NUM_TB-1:0] tb_prv_q;
  logic fdiv_src_q;
  logic [3:0] fdiv_cnt_q;
  logic [NUM_CNT-1:0] chan_out;
  logic [CNT_W-1:0] chan_count [NUM_CNT];
  wire board_tick;
  wire alt_rise;
  wire sel_tick;
  wire [NUM_TB-1:0] tb_step;
  wire [POOL_W-1:0] sel_pool;
  wire [NUM_CNT-1:0] chan_src;
  wire fdiv_lvl;
  wire fdiv_edge;
  wire [3:0] fdiv_last;
  wire fdiv_wrap;

  // ---------------------------------------------------------------
  // Board clock and counter input clock
  // ---------------------------------------------------------------
  // Internal board tick at 10 MHz, or rising edges of the alternate clock pin.
  assign board_tick = (board_div_q == BOARD_LAST);
  assign alt_rise = alt_board_clk & ~alt_q;
  assign sel_tick = board_clk_sel ? alt_rise : board_tick;

  // Board divider and the divide-by-ten prescaler.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      board_div_q <= 3'h0;
      alt_q <= 1'b0;
      pre_q <= 4'h0;
    end
    else if (ce)
    begin
      board_div_q <= board_tick ? 3'h0 : board_div_q + 3'h1;
      alt_q <= alt_board_clk;
      if (sel_tick)
        pre_q <= (pre_q == PRE_LAST) ? 4'h0 : pre_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Timebases
  // ---------------------------------------------------------------
  // Timebase zero steps on the prescaler wrap; each later one on its predecessor's rise.
  assign tb_step[0] = sel_tick && (pre_q == PRE_LAST);

  genvar k;
  generate
    for (k = 1; k < NUM_TB; k++)
    begin : g_step
      assign tb_step[k] = tb_lvl_q[k-1] & ~tb_prv_q[k-1];
    end
    for (k = 0; k < NUM_TB; k++)
    begin : g_tb
      // Decade divider producing a timebase level: high 6 board ticks of 10 on timebase zero, 1 predecessor period of 10 on later ones.
      always_ff @(posedge mclk)
      begin
        if (sys_rst)
        begin
          tb_cnt_q[k] <= 4'h0;
          tb_lvl_q[k] <= 1'b0;
          tb_prv_q[k] <= 1'b0;
        end
        else if (ce)
        begin
          tb_prv_q[k] <= tb_lvl_q[k];
          if (tb_step[k])
          begin
            tb_cnt_q[k] <= (tb_cnt_q[k] == TB_LAST) ? 4'h0 : tb_cnt_q[k] + 4'h1;
            tb_lvl_q[k] <= (k == 0) ? 1'b1 : (tb_cnt_q[k] == TB_LAST);
          end
          else if (k == 0 && sel_tick && pre_q == PRE_HALF)
            tb_lvl_q[k] <= 1'b0;
          else if (k != 0 && tb_step[(k == 0) ? 0 : k-1] == 1'b0 && tb_cnt_q[k] == TB_HALF)
            tb_lvl_q[k] <= 1'b0;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Source selection and counters
  // ---------------------------------------------------------------
  // Any source pin, gate pin or timebase may clock any counter.
  assign sel_pool = {tb_lvl_q, gate_pin, src_pin};

  generate
    for (k = 0; k < NUM_CNT; k++)
    begin : g_chan
      assign chan_src[k] = (cnt_src_sel[k] < 4'(POOL_W)) ? sel_pool[cnt_src_sel[k]] : 1'b0;

      gpct_channel u_chan (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .arm(cnt_arm[k]),
        .src_lvl(chan_src[k]),
        .gate_lvl(gate_pin[k]),
        .edge_fall(cnt_edge_fall[k]),
        .gate_mode(cnt_gate_mode[k]),
        .gate_high(cnt_gate_high[k]),
        .out_toggle(cnt_out_toggle[k]),
        .limit(cnt_limit[k]),
        .count_q(chan_count[k]),
        .out_q(chan_out[k])
      );

      // Values and outputs leave from channel flip-flops; chaining must bring an output back in through a source pin.
      assign cnt_value[k] = chan_count[k];
      assign cnt_out[k] = chan_out[k];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Frequency division output
  // ---------------------------------------------------------------
  // Toggles after every ratio rising edges of the selected source.
  assign fdiv_lvl = (fdiv_src_sel < 4'(POOL_W)) ? sel_pool[fdiv_src_sel] : 1'b0;
  assign fdiv_edge = fdiv_lvl & ~fdiv_src_q;
  assign fdiv_last = fdiv_ratio - 4'h1;
  assign fdiv_wrap = fdiv_edge && (fdiv_cnt_q == fdiv_last);

  // Division counter and output flip-flop.
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      fdiv_src_q <= 1'b0;
      fdiv_cnt_q <= FDIV_CNT_RST;
      freq_division_output <= 1'b0;
    end
    else if (ce)
    begin
      fdiv_src_q <= fdiv_lvl;
      if (!fdiv_en)
      begin
        fdiv_cnt_q <= FDIV_CNT_RST;
        freq_division_output <= 1'b0;
      end
      else if (fdiv_edge)
      begin
        fdiv_cnt_q <= fdiv_wrap ? FDIV_CNT_RST : fdiv_cnt_q + 4'h1;
        freq_division_output <= freq_division_output ^ fdiv_wrap;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  prescale_wrap_a: assert property (ce && sel_tick && pre_q == PRE_LAST |=> pre_q == 4'h0)
    else $error("prescaler did not wrap after ten ticks");
  board_tick_a: assert property (ce && !board_clk_sel && board_tick
      |=> !board_tick [*4] ##1 (board_tick || !ce || $past(!ce)))
    else $error("board tick spacing wrong");
  tb_chain_a: assert property (ce && tb_step[1] && tb_cnt_q[1] == TB_LAST
      |=> tb_cnt_q[1] == 4'h0)
    else $error("timebase decade did not wrap");
  fdiv_toggle_a: assert property (ce && fdiv_en && fdiv_wrap
      |=> freq_division_output != $past(freq_division_output))
    else $error("division output did not toggle");
  fdiv_off_a: assert property (ce && !fdiv_en |=> !freq_division_output)
    else $error("division output active while disabled");

endmodule

// ===== gpct_sig_source.sv
// Signal source model driving the count-source and gate pins of the timer.
`timescale 1ns/1ps
module gpct_sig_source
  import gpct_pkg::*;
(
  input wire logic mclk, // System clock.
  input wire logic chain_en, // Route counter 0 output onto source pin 1.
  input wire logic [NUM_CNT-1:0] cnt_out, // Counter outputs for chaining.
  output logic [NUM_CNT-1:0] src_pin, // Count-source pins.
  output logic [NUM_CNT-1:0] gate_pin // Gate pins.
);
  logic [NUM_CNT-1:0] src_q = '0;
  // Source pin 1 follows counter 0 output while chaining is on.
  assign src_pin = chain_en ? {src_q[2], cnt_out[0], src_q[0]} : src_q;
  initial gate_pin = '0;
  // Sends n pulses of ten clocks each, so sources never run above 5 MHz.
  task automatic pulses(input int k, input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (5) @(negedge mclk);
      src_q[k] = 1'b1;
      repeat (5) @(negedge mclk);
      src_q[k] = 1'b0;
    end
  endtask
  // Moves one gate pin just after a clock edge.
  task automatic set_gate(input int k, input logic v);
    @(negedge mclk);
    gate_pin[k] = v;
  endtask
endmodule

// ===== test_general_purpose_counter_timer.sv
// Self-checking testbench of the three-counter timer with a signal source model.
`timescale 1ns/1ps
module test_general_purpose_counter_timer
  import gpct_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic board_clk_sel = 1'b0;
  logic alt_board_clk = 1'b0;
  logic chain_en = 1'b0;
  logic ce_in = 1'b1;
  logic fdiv_en = 1'b0;
  logic fdiv_out;
  logic [3:0] fdiv_src_sel = 4'h0;
  logic [3:0] fdiv_ratio = 4'h1;
  logic [NUM_CNT-1:0] arm = '0, fall = '0, high = '0, tog = '0, cnt_out, src_pin, gate_pin;
  logic [3:0] src_sel [NUM_CNT];
  gate_mode_t mode [NUM_CNT];
  logic [CNT_W-1:0] lim [NUM_CNT];
  logic [CNT_W-1:0] val [NUM_CNT];
  logic [19:0] exp_q [$];
  logic [19:0] e;
  logic [15:0] seen;
  event chk_ev;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int tb_sel [3] = '{0, 0, 1};
  int tb_per [3] = '{50, 500, 20};
  // Clock of 20 ns and an alternate board clock at half its rate.
  initial forever #10 mclk = ~mclk;
  always @(negedge mclk) alt_board_clk <= ~alt_board_clk;
  gpct_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce_in), .board_clk_sel(board_clk_sel),
    .alt_board_clk(alt_board_clk), .src_pin(src_pin), .gate_pin(gate_pin), .cnt_arm(arm),
    .cnt_src_sel(src_sel), .cnt_edge_fall(fall), .cnt_gate_mode(mode), .cnt_gate_high(high),
    .cnt_out_toggle(tog), .cnt_limit(lim), .fdiv_en(fdiv_en), .fdiv_src_sel(fdiv_src_sel),
    .fdiv_ratio(fdiv_ratio), .cnt_out(cnt_out), .cnt_value(val),
    .freq_division_output(fdiv_out));
  gpct_sig_source u_src (.mclk(mclk), .chain_en(chain_en), .cnt_out(cnt_out),
    .src_pin(src_pin), .gate_pin(gate_pin));
  // Compares one value and counts the comparison.
  task automatic check(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  // Notes an expectation: kind 0 count, 1 output, 2 count within one, 3 division output.
  task automatic expect_res(input logic [1:0] k, input logic [1:0] c, input logic [15:0] v);
    exp_q.push_back({k, c, v});
    ->chk_ev;
    #1;
  endtask
  // Watches the outputs and settles the oldest note.
  always @(chk_ev)
  begin
    e = exp_q.pop_front();
    case (e[19:18])
      2'd0: seen = val[e[17:16]];
      2'd1: seen = {15'h0, cnt_out[e[17:16]]};
      2'd2: seen = (val[e[17:16]] + 16'h1 >= e[15:0] && val[e[17:16]] <= e[15:0] + 16'h1) ?
        e[15:0] : val[e[17:16]];
      default: seen = {15'h0, fdiv_out};
    endcase
    check(seen, e[15:0]);
  end
  // Disarms, programs and rearms one counter.
  task automatic cfg(input int c, input logic [3:0] s, input logic f, input gate_mode_t m,
    input logic h, input logic t, input logic [15:0] l);
    @(negedge mclk);
    arm[c] = 1'b0;
    src_sel[c] = s;
    fall[c] = f;
    mode[c] = m;
    high[c] = h;
    tog[c] = t;
    lim[c] = l;
    @(negedge mclk);
    arm[c] = 1'b1;
    repeat (3) @(negedge mclk);
  endtask
  task automatic pulse_wait(input int k, input int n);
    u_src.pulses(k, n);
    repeat (3) @(negedge mclk);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end
  // Main sequence of tests.
  initial
  begin
    int n;
    int l;
    int s;
    logic p;
    void'($urandom(32'h671ff7bc));
    foreach (lim[i])
    begin
      src_sel[i] = 4'hf;
      mode[i] = GATE_NONE;
      lim[i] = 16'hffff;
    end
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      expect_res(2'd0, 2'(c), COUNT_RST);
      expect_res(2'd1, 2'(c), 16'h0000);
    end
    expect_res(2'd3, 2'd0, 16'h0000);
    $display("Test reset done");
    for (int c = 0; c < 3; c++)
    begin
      s = $urandom % 3;
      n = 1 + $urandom % 20;
      cfg(c, 4'(s), 1'($urandom % 2), GATE_NONE, 1'b0, 1'b0, 16'hffff);
      pulse_wait(s, n);
      expect_res(2'd0, 2'(c), 16'(n));
    end
    $display("Test event counting done");
    for (int i = 0; i < 2; i++)
    begin
      p = i[0];
      n = 1 + $urandom % 10;
      u_src.set_gate(0, ~p);
      cfg(0, SEL_SRC0, 1'b0, GATE_LEVEL, p, 1'b0, 16'hffff);
      pulse_wait(0, 3);
      expect_res(2'd0, 2'd0, 16'h0000);
      u_src.set_gate(0, p);
      pulse_wait(0, n);
      expect_res(2'd0, 2'd0, 16'(n));
      u_src.set_gate(0, ~p);
      pulse_wait(0, 2);
      expect_res(2'd0, 2'd0, 16'(n));
      u_src.set_gate(2, ~p);
      cfg(2, 4'h2, 1'b0, GATE_EDGE, p, 1'b0, 16'hffff);
      pulse_wait(2, 2);
      expect_res(2'd0, 2'd2, 16'h0000);
      u_src.set_gate(2, p);
      pulse_wait(2, 3);
      u_src.set_gate(2, ~p);
      pulse_wait(2, 2);
      expect_res(2'd0, 2'd2, 16'h0005);
    end
    $display("Test gating done");
    for (int f = 0; f < 2; f++)
    begin
      l = 2 + $urandom % 3;
      cfg(1, 4'h1, f[0], GATE_NONE, 1'b0, 1'b0, 16'(l));
      pulse_wait(1, l);
      expect_res(2'd0, 2'd1, 16'(l));
      pulse_wait(1, 1);
      expect_res(2'd0, 2'd1, 16'h0000);
      expect_res(2'd1, 2'd1, 16'h0001);
      pulse_wait(1, 1);
      expect_res(2'd1, 2'd1, 16'h0000);
      expect_res(2'd0, 2'd1, 16'h0001);
      cfg(1, 4'h1, f[0], GATE_NONE, 1'b0, 1'b1, 16'(l));
      pulse_wait(1, l + 1);
      expect_res(2'd1, 2'd1, 16'h0001);
      pulse_wait(1, l + 1);
      expect_res(2'd1, 2'd1, 16'h0000);
    end
    $display("Test terminal count done");
    cfg(0, SEL_SRC0, 1'b0, GATE_NONE, 1'b0, 1'b1, 16'h0001);
    chain_en = 1'b1;
    cfg(1, 4'h1, 1'b0, GATE_NONE, 1'b0, 1'b0, 16'hffff);
    pulse_wait(0, 8);
    expect_res(2'd0, 2'd1, 16'h0002);
    expect_res(2'd0, 2'd0, 16'h0000);
    chain_en = 1'b0;
    $display("Test chaining done");
    for (int i = 0; i < 3; i++)
    begin
      board_clk_sel = tb_sel[i][0];
      cfg(2, SEL_TB0 + 4'(i % 2), 1'b0, GATE_NONE, 1'b0, 1'b0, 16'hffff);
      repeat (tb_per[i] * 10) @(negedge mclk);
      expect_res(2'd2, 2'd2, 16'h000a);
    end
    board_clk_sel = 1'b0;
    $display("Test timebases done");
    s = $urandom % 3;
    n = 1 + $urandom % 15;
    fdiv_src_sel = 4'(s);
    fdiv_ratio = 4'(n);
    fdiv_en = 1'b1;
    pulse_wait(s, n);
    expect_res(2'd3, 2'd0, 16'h0001);
    pulse_wait(s, n);
    expect_res(2'd3, 2'd0, 16'h0000);
    // With the clock enable low the division output must not move.
    @(negedge mclk);
    ce_in = 1'b0;
    pulse_wait(s, n);
    @(negedge mclk);
    ce_in = 1'b1;
    expect_res(2'd3, 2'd0, 16'h0000);
    $display("Test frequency division done");
    finish_test();
  end
endmodule
